// File: logic/can_limit_defines.svh
// register offsets, field positions, reset values and limits
`ifndef CAN_LIMIT_DEFINES_SVH
`define CAN_LIMIT_DEFINES_SVH

`define OFS_CONTROL     6'h00
`define OFS_STATUS      6'h04
`define OFS_ZERO        6'h08
`define OFS_ONE         6'h0c
`define OFS_GLOBAL      6'h20
`define OFS_IRQ_STATUS  6'h24
`define OFS_IRQ_MASK    6'h28

`define BIT_SOFT_INIT   0
`define BIT_LIMIT_SEL   1
`define BIT_ERR_IRQ_EN  2
`define BIT_EXCEEDED    6
`define BIT_BUS_OFF     7
`define BIT_GLOBAL_EN   0
`define BIT_MOD0_EN     1
`define BIT_MOD1_EN     2

`define RST_CONTROL     3'h1
`define RST_ZERO        8'h00
`define RST_ONE         8'h00
`define RST_GLOBAL      3'h0

`define LIMIT_LOW       9'h060
`define LIMIT_HIGH      9'h080

`endif

// File: logic/can_limit_pkg.sv
// types shared by the error-limit and bit-timing logic
`default_nettype none

package can_limit_pkg;

  typedef struct packed {
    logic error_irq_enable;
    logic error_limit_select;
    logic soft_init_hold;
  } control_type;

  typedef struct packed {
    logic [1:0] phase_segment_ctrl;
    logic [5:0] baud_prescaler_bits;
  } timing_zero_type;

  typedef struct packed {
    logic       sample_rate;
    logic [2:0] second_timing_segment;
    logic [3:0] first_timing_segment;
  } timing_one_type;

  typedef struct packed {
    logic module1_irq_enable;
    logic module0_irq_enable;
    logic global_irq_enable;
  } irq_control_type;

endpackage : can_limit_pkg

`default_nettype wire

// File: logic/can_limit_channel.sv
// one controller: error limit compare, control and timing registers
`default_nettype none
`include "can_limit_defines.svh"

module can_limit_channel (
  input  wire logic                            clk_in,
  input  wire logic                            rst_n_in,
  input  wire logic                            wr_control_in,
  input  wire logic                            wr_zero_in,
  input  wire logic                            wr_one_in,
  input  wire logic [7:0]                      wdata_in,
  input  wire logic [8:0]                      tx_count_in,
  input  wire logic [8:0]                      rx_count_in,
  input  wire logic                            bus_off_in,
  output var  can_limit_pkg::control_type      control_out,
  output var  logic                            exceeded_out,
  output var  can_limit_pkg::timing_zero_type  zero_out,
  output var  can_limit_pkg::timing_one_type   one_out,
  output var  logic                            event_out,
  output var  logic                            load_out,
  output var  can_limit_pkg::timing_zero_type  engine_zero_out,
  output var  can_limit_pkg::timing_one_type   engine_one_out
);

  logic [8:0]                 limit;
  logic                       next_exceeded;
  logic                       timing_open;
  logic                       clear_blocked;
  logic                       clearing;
  can_limit_pkg::control_type next_control;

  ////////////////////////////////////////////////////////////////////////////
  // error limit compare

  assign limit = control_out.error_limit_select ? `LIMIT_HIGH : `LIMIT_LOW;
  assign next_exceeded = (tx_count_in > limit) || (rx_count_in > limit);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      exceeded_out <= 1'b0;
    end else begin
      exceeded_out <= next_exceeded;
    end
  end

  // set always alerts, clear alerts only with the high limit
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      event_out <= 1'b0;
    end else begin
      event_out <= (next_exceeded && !exceeded_out) ||
                   (!next_exceeded && exceeded_out && control_out.error_limit_select);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register

  assign clear_blocked = (one_out.first_timing_segment == 4'h0) &&
                         (one_out.second_timing_segment == 3'h0);

  always_comb begin
    next_control = can_limit_pkg::control_type'(wdata_in[2:0]);
    if (control_out.soft_init_hold && clear_blocked) begin
      next_control.soft_init_hold = 1'b1;
    end
  end

  assign clearing = wr_control_in && control_out.soft_init_hold && !next_control.soft_init_hold;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      control_out <= can_limit_pkg::control_type'(`RST_CONTROL);
    end else if (wr_control_in) begin
      control_out <= next_control;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timing registers and engine copy

  assign timing_open = control_out.soft_init_hold && !bus_off_in;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      zero_out <= can_limit_pkg::timing_zero_type'(`RST_ZERO);
      one_out  <= can_limit_pkg::timing_one_type'(`RST_ONE);
    end else begin
      if (wr_zero_in && timing_open) begin
        zero_out <= can_limit_pkg::timing_zero_type'(wdata_in);
      end
      if (wr_one_in && timing_open) begin
        one_out <= can_limit_pkg::timing_one_type'(wdata_in);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      load_out        <= 1'b0;
      engine_zero_out <= can_limit_pkg::timing_zero_type'(`RST_ZERO);
      engine_one_out  <= can_limit_pkg::timing_one_type'(`RST_ONE);
    end else begin
      load_out <= clearing;
      if (clearing) begin
        engine_zero_out <= zero_out;
        engine_one_out  <= one_out;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_limit_value;
    @(posedge clk_in) disable iff (!rst_n_in)
      limit == (control_out.error_limit_select ? 9'h080 : 9'h060);
  endproperty
  a_limit_value: assert property (p_limit_value) else $error("wrong error limit");

  property p_flag_set;
    @(posedge clk_in) disable iff (!rst_n_in)
      (tx_count_in > limit || rx_count_in > limit) |=> exceeded_out;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("exceeded flag not set");

  property p_flag_clear;
    @(posedge clk_in) disable iff (!rst_n_in)
      (tx_count_in <= limit && rx_count_in <= limit) |=> !exceeded_out;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("exceeded flag not cleared");

  property p_clear_event;
    @(posedge clk_in) disable iff (!rst_n_in)
      (exceeded_out && !next_exceeded) |=> (event_out == $past(control_out.error_limit_select));
  endproperty
  a_clear_event: assert property (p_clear_event) else $error("clear alert wrong");

  property p_load_copy;
    @(posedge clk_in) disable iff (!rst_n_in)
      clearing |=> load_out && engine_one_out == $past(one_out) && engine_zero_out == $past(zero_out);
  endproperty
  a_load_copy: assert property (p_load_copy) else $error("timing not copied");

  property p_clear_block;
    @(posedge clk_in) disable iff (!rst_n_in)
      (wr_control_in && control_out.soft_init_hold && clear_blocked) |=> control_out.soft_init_hold;
  endproperty
  a_clear_block: assert property (p_clear_block) else $error("init cleared with zero segments");

  property p_timing_guard;
    @(posedge clk_in) disable iff (!rst_n_in)
      !timing_open |=> $stable(zero_out) && $stable(one_out);
  endproperty
  a_timing_guard: assert property (p_timing_guard) else $error("timing written while closed");

  c_load: cover property (@(posedge clk_in) disable iff (!rst_n_in) load_out);
  c_set_clear: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    $fell(exceeded_out) && event_out);

endmodule : can_limit_channel

`default_nettype wire

// File: logic/can_error_limit_bit_timing.sv
// two-controller error limit interrupt and bit-timing registers, Avalon-MM slave
//
// The Avalon-MM slave port and the register addresses were decided locally.
`default_nettype none
`include "can_limit_defines.svh"

module can_error_limit_bit_timing (
  input  wire logic                                  CLK_IN,
  input  wire logic                                  NRST_IN,
  input  wire logic [5:0]                            AVS_ADDRESS_IN,
  input  wire logic                                  AVS_READ_IN,
  input  wire logic                                  AVS_WRITE_IN,
  input  wire logic [31:0]                           AVS_WRITEDATA_IN,
  input  wire logic [3:0]                            AVS_BYTEENABLE_IN,
  output var  logic [31:0]                           AVS_READDATA_OUT,
  output var  logic                                  AVS_WAITREQUEST_OUT,
  input  wire logic [1:0][8:0]                       TX_COUNT_IN,
  input  wire logic [1:0][8:0]                       RX_COUNT_IN,
  input  wire logic [1:0]                            BUS_OFF_IN,
  output var  logic [1:0]                            LOAD_OUT,
  output var  can_limit_pkg::timing_zero_type [1:0]  ENGINE_ZERO_OUT,
  output var  can_limit_pkg::timing_one_type [1:0]   ENGINE_ONE_OUT,
  output var  logic                                  IRQ_OUT
);

  logic                            rst_meta;
  logic                            rst_n;
  logic                            ack;
  logic [5:0]                      addr;
  logic [5:0]                      local_addr;
  logic                            wr_go;
  logic [7:0]                      wbyte;
  logic [31:0]                     next_readdata;
  can_limit_pkg::irq_control_type  irq_control;
  logic [1:0]                      irq_status;
  logic [1:0]                      irq_mask;
  logic [1:0]                      module_enable;
  logic [1:0]                      gated;

  can_limit_pkg::control_type      control [2];
  can_limit_pkg::timing_zero_type  zero [2];
  can_limit_pkg::timing_one_type   one [2];
  logic [1:0]                      exceeded;
  logic [1:0]                      event_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle per access

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= (AVS_READ_IN || AVS_WRITE_IN) && !ack;
    end
  end

  assign AVS_WAITREQUEST_OUT = (AVS_READ_IN || AVS_WRITE_IN) && !ack;

  assign addr       = {AVS_ADDRESS_IN[5:2], 2'b00};
  assign local_addr = {2'b00, addr[3:0]};
  assign wr_go      = AVS_WRITE_IN && ack && AVS_BYTEENABLE_IN[0];
  assign wbyte      = AVS_WRITEDATA_IN[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // per-controller logic

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      logic hit;

      assign hit = (addr[5:4] == 2'(ch));

      can_limit_channel u_chan (
        .clk_in          (CLK_IN),
        .rst_n_in        (rst_n),
        .wr_control_in   (wr_go && hit && local_addr == `OFS_CONTROL),
        .wr_zero_in      (wr_go && hit && local_addr == `OFS_ZERO),
        .wr_one_in       (wr_go && hit && local_addr == `OFS_ONE),
        .wdata_in        (wbyte),
        .tx_count_in     (TX_COUNT_IN[ch]),
        .rx_count_in     (RX_COUNT_IN[ch]),
        .bus_off_in      (BUS_OFF_IN[ch]),
        .control_out     (control[ch]),
        .exceeded_out    (exceeded[ch]),
        .zero_out        (zero[ch]),
        .one_out         (one[ch]),
        .event_out       (event_pulse[ch]),
        .load_out        (LOAD_OUT[ch]),
        .engine_zero_out (ENGINE_ZERO_OUT[ch]),
        .engine_one_out  (ENGINE_ONE_OUT[ch])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // global enables

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      irq_control <= can_limit_pkg::irq_control_type'(`RST_GLOBAL);
    end else if (wr_go && addr == `OFS_GLOBAL) begin
      irq_control <= can_limit_pkg::irq_control_type'(wbyte[2:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky alert status, mask and interrupt line

  // an alert in the same cycle as its write-one-to-clear survives
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= 2'h0;
    end else begin
      if (wr_go && addr == `OFS_IRQ_STATUS) begin
        irq_status <= (irq_status & ~wbyte[1:0]) | event_pulse;
      end else begin
        irq_status <= irq_status | event_pulse;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= 2'h0;
    end else if (wr_go && addr == `OFS_IRQ_MASK) begin
      irq_mask <= wbyte[1:0];
    end
  end

  assign module_enable = {irq_control.module1_irq_enable, irq_control.module0_irq_enable};

  assign gated = irq_status & irq_mask & module_enable &
                 {control[1].error_irq_enable, control[0].error_irq_enable};

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= irq_control.global_irq_enable && (gated != 2'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  // all unlisted bits and addresses read zero
  always_comb begin
    next_readdata = 32'h0;
    if (addr[5] == 1'b0) begin
      unique case (local_addr)
        `OFS_CONTROL: next_readdata[2:0] = control[addr[4]];
        `OFS_STATUS: begin
          next_readdata[`BIT_EXCEEDED] = exceeded[addr[4]];
          next_readdata[`BIT_BUS_OFF]  = BUS_OFF_IN[addr[4]];
        end
        `OFS_ZERO: next_readdata[7:0] = zero[addr[4]];
        `OFS_ONE:  next_readdata[7:0] = one[addr[4]];
        default:   next_readdata = 32'h0;
      endcase
    end else begin
      unique case (addr)
        `OFS_GLOBAL:     next_readdata[2:0] = irq_control;
        `OFS_IRQ_STATUS: next_readdata[1:0] = irq_status;
        `OFS_IRQ_MASK:   next_readdata[1:0] = irq_mask;
        default:         next_readdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      AVS_READDATA_OUT <= 32'h0;
    end else if (AVS_READ_IN && !ack) begin
      AVS_READDATA_OUT <= next_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_irq_gate;
    @(posedge CLK_IN) disable iff (!rst_n)
      IRQ_OUT |-> $past(irq_control.global_irq_enable) && ($past(gated) != 2'h0);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt without all enables");

  property p_irq_raise;
    @(posedge CLK_IN) disable iff (!rst_n)
      (irq_control.global_irq_enable && gated != 2'h0) |=> IRQ_OUT;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("enabled alert not raised");

  property p_alert_sticky;
    @(posedge CLK_IN) disable iff (!rst_n)
      event_pulse[0] |=> irq_status[0] [*2];
  endproperty
  a_alert_sticky: assert property (p_alert_sticky) else $error("alert lost");

  property p_answer;
    @(posedge CLK_IN) disable iff (!rst_n)
      AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");

  property p_unmapped_zero;
    @(posedge CLK_IN) disable iff (!rst_n)
      (AVS_READ_IN && !ack && addr[5:4] == 2'b11) |=> AVS_READDATA_OUT == 32'h0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  property p_upper_zero;
    @(posedge CLK_IN) disable iff (!rst_n)
      AVS_READDATA_OUT[31:8] == 24'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");

  property p_alert_sticky1;
    @(posedge CLK_IN) disable iff (!rst_n)
      event_pulse[1] |=> irq_status[1] [*2];
  endproperty
  a_alert_sticky1: assert property (p_alert_sticky1) else $error("alert one lost");

  property p_status_hold;
    @(posedge CLK_IN) disable iff (!rst_n)
      (!(wr_go && addr == `OFS_IRQ_STATUS) && event_pulse == 2'h0) |=> $stable(irq_status);
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("alert changed by itself");

  property p_alert_clear;
    @(posedge CLK_IN) disable iff (!rst_n)
      (wr_go && addr == `OFS_IRQ_STATUS && wbyte[1:0] == 2'h3 && event_pulse == 2'h0) |=> irq_status == 2'h0;
  endproperty
  a_alert_clear: assert property (p_alert_clear) else $error("alert not cleared");

  property p_global_write;
    @(posedge CLK_IN) disable iff (!rst_n)
      (wr_go && addr == `OFS_GLOBAL) |=> {5'h00, irq_control} == ($past(wbyte) & 8'h07);
  endproperty
  a_global_write: assert property (p_global_write) else $error("global enables not written");

  property p_mask_write;
    @(posedge CLK_IN) disable iff (!rst_n)
      (wr_go && addr == `OFS_IRQ_MASK) |=> {6'h00, irq_mask} == ($past(wbyte) & 8'h03);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask not written");

  property p_irq_drop;
    @(posedge CLK_IN) disable iff (!rst_n)
      !irq_control.global_irq_enable |=> !IRQ_OUT;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("interrupt without global enable");

  property p_error_gate;
    @(posedge CLK_IN) disable iff (!rst_n)
      (!control[0].error_irq_enable && !control[1].error_irq_enable) |=> !IRQ_OUT;
  endproperty
  a_error_gate: assert property (p_error_gate) else $error("interrupt without error enable");

  property p_read_hold;
    @(posedge CLK_IN) disable iff (!rst_n)
      ack |=> $stable(AVS_READDATA_OUT);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data moved after answer");

  property p_ack_pulse;
    @(posedge CLK_IN) disable iff (!rst_n)
      ack |=> !ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("answer longer than one cycle");

  c_irq: cover property (@(posedge CLK_IN) disable iff (!rst_n) $rose(IRQ_OUT));
  c_both: cover property (@(posedge CLK_IN) disable iff (!rst_n) irq_status == 2'h3);

endmodule : can_error_limit_bit_timing

`default_nettype wire

// File: test/can_engine_model.sv
// engine-side model: error counters, bus-off and capture of timing loads
`default_nettype none

module can_engine_model (
  input  wire logic                                  clk_in,
  input  wire logic [1:0]                            load_in,
  input  wire can_limit_pkg::timing_zero_type [1:0]  engine_zero_in,
  input  wire can_limit_pkg::timing_one_type [1:0]   engine_one_in,
  output var  logic [1:0][8:0]                       tx_count_out,
  output var  logic [1:0][8:0]                       rx_count_out,
  output var  logic [1:0]                            bus_off_out
);
  timeunit 1ns;
  timeprecision 1ps;

  int               load_cnt [2];
  logic [1:0][15:0] loaded;

  initial begin
    tx_count_out = '0;
    rx_count_out = '0;
    bus_off_out  = '0;
    loaded       = '0;
    load_cnt[0]  = 0;
    load_cnt[1]  = 0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // counters change just after an edge, as the engine would
  task automatic set_counts(input int ch, input logic [8:0] tx, input logic [8:0] rx, input logic off);
    @(posedge clk_in);
    tx_count_out[ch] <= tx;
    rx_count_out[ch] <= rx;
    bus_off_out[ch]  <= off;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // engine takes the timing pair on each load pulse
  always @(posedge clk_in) begin
    for (int i = 0; i < 2; i++) begin
      if (load_in[i] === 1'b1) begin
        load_cnt[i] <= load_cnt[i] + 1;
        loaded[i]   <= {engine_zero_in[i], engine_one_in[i]};
      end
    end
  end
endmodule // can_engine_model

`default_nettype wire

// File: test/testbench.sv
// self-checking bench for the error limit and bit-timing block
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                                 clk;
  logic                                 rst_n;
  logic [5:0]                           address;
  logic                                 read;
  logic                                 write;
  logic [31:0]                          writedata;
  logic [31:0]                          readdata;
  logic                                 waitrequest;
  logic [1:0][8:0]                      tx_count;
  logic [1:0][8:0]                      rx_count;
  logic [1:0]                           bus_off;
  logic [1:0]                           load;
  can_limit_pkg::timing_zero_type [1:0] engine_zero;
  can_limit_pkg::timing_one_type [1:0]  engine_one;
  logic                                 irq;
  int                                   error_cnt;
  int                                   total_checks;
  int                                   cycles;

  can_error_limit_bit_timing u_can_error_limit_bit_timing (
    .CLK_IN(clk), .NRST_IN(rst_n), .AVS_ADDRESS_IN(address), .AVS_READ_IN(read),
    .AVS_WRITE_IN(write), .AVS_WRITEDATA_IN(writedata), .AVS_BYTEENABLE_IN(4'hf),
    .AVS_READDATA_OUT(readdata), .AVS_WAITREQUEST_OUT(waitrequest), .TX_COUNT_IN(tx_count),
    .RX_COUNT_IN(rx_count), .BUS_OFF_IN(bus_off), .LOAD_OUT(load), .ENGINE_ZERO_OUT(engine_zero),
    .ENGINE_ONE_OUT(engine_one), .IRQ_OUT(irq)
  );

  can_engine_model u_can_engine_model (
    .clk_in(clk), .load_in(load), .engine_zero_in(engine_zero), .engine_one_in(engine_one),
    .tx_count_out(tx_count), .rx_count_out(rx_count), .bus_off_out(bus_off)
  );

  always #5 clk = ~clk;

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  // held until waitrequest is sampled low at a rising edge, data taken and request released there
  task automatic bus_xfer(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    address   <= a;
    writedata <= d;
    write     <= wr;
    read      <= !wr;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic bus_write(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_xfer(1'b1, a, d, q);
  endtask

  task automatic expect_reg(input string what, input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus_xfer(1'b0, a, 32'h0, q);
    check(what, q, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    expect_reg("control0", 6'h00, 32'h01);
    expect_reg("timing zero1", 6'h18, 32'h00);
    expect_reg("timing one1", 6'h1c, 32'h00);
    expect_reg("status0", 6'h04, 32'h00);
    expect_reg("unmapped", 6'h30, 32'h00);
    $display("test reset done");
  endtask

  task automatic test_timing();
    bus_write(6'h08, 32'h0000_00a5);
    expect_reg("timing zero0", 6'h08, 32'ha5);
    bus_write(6'h0c, 32'hffff_ffff);
    expect_reg("timing one0", 6'h0c, 32'hff);
    u_can_engine_model.set_counts(0, 9'h000, 9'h000, 1'b1);
    bus_write(6'h08, 32'h11);
    expect_reg("status0 bus off", 6'h04, 32'h80);
    expect_reg("timing zero0 bus off", 6'h08, 32'ha5);
    u_can_engine_model.set_counts(0, 9'h000, 9'h000, 1'b0);
    $display("test timing done");
  endtask

  // timing set first, then init released
  task automatic test_init_load();
    bus_write(6'h10, 32'h00);
    expect_reg("control1 blocked", 6'h10, 32'h01);
    bus_write(6'h00, 32'h00);
    settle(2);
    check("loads0", u_can_engine_model.load_cnt[0], 32'd1);
    check("engine pair0", u_can_engine_model.loaded[0], 32'ha5ff);
    check("loads1", u_can_engine_model.load_cnt[1], 32'd0);
    bus_write(6'h08, 32'h33);
    expect_reg("timing zero0 run", 6'h08, 32'ha5);
    check("engine zero0", engine_zero[0], 32'ha5);
    $display("test init load done");
  endtask

  task automatic test_limit(input int ch, input logic sel);
    logic [8:0] lim;
    logic [5:0] base;
    lim  = sel ? 9'd128 : 9'd96;
    base = ch[0] ? 6'h10 : 6'h00;
    bus_write(base, 32'h04 | (32'(sel) << 1));
    bus_write(6'h20, 32'h07);
    bus_write(6'h28, 32'h03);
    u_can_engine_model.set_counts(ch, lim, 9'h000, 1'b0);
    settle(4);
    expect_reg("status at limit", base + 6'h04, 32'h00);
    u_can_engine_model.set_counts(ch, lim, lim + 9'd1, 1'b0);
    settle(4);
    expect_reg("status above limit", base + 6'h04, 32'h40);
    expect_reg("other status", base ^ 6'h14, 32'h00);
    expect_reg("alert", 6'h24, 32'h1 << ch);
    check("irq set", irq, 32'h1);
    bus_write(6'h24, 32'h1 << ch);
    settle(2);
    check("irq cleared", irq, 32'h0);
    u_can_engine_model.set_counts(ch, 9'h000, lim, 1'b0);
    settle(4);
    expect_reg("status back", base + 6'h04, 32'h00);
    expect_reg("clear alert", 6'h24, 32'(sel) << ch);
    check("irq on clear", irq, 32'(sel));
    bus_write(6'h24, 32'h3);
    $display("test limit done");
  endtask

  task automatic test_gating();
    bus_write(6'h00, 32'h00);
    u_can_engine_model.set_counts(0, 9'd97, 9'h000, 1'b0);
    settle(4);
    check("irq no error enable", irq, 32'h0);
    bus_write(6'h00, 32'h04);
    settle(2);
    check("irq all enables", irq, 32'h1);
    bus_write(6'h20, 32'h05);
    settle(2);
    check("irq no module enable", irq, 32'h0);
    bus_write(6'h20, 32'h06);
    settle(2);
    check("irq no global enable", irq, 32'h0);
    u_can_engine_model.set_counts(0, 9'h000, 9'h000, 1'b0);
    bus_write(6'h24, 32'h3);
    $display("test gating done");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk          = 1'b0;
    rst_n        = 1'b0;
    address      = '0;
    read         = 1'b0;
    write        = 1'b0;
    writedata    = '0;
    error_cnt    = 0;
    total_checks = 0;
    cycles       = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    test_reset();
    test_timing();
    test_init_load();
    test_limit(0, 1'b0);
    test_limit(0, 1'b1);
    test_limit(1, 1'b1);
    test_limit(1, 1'b0);
    test_gating();
    close_out();
  end
endmodule // testbench

`default_nettype wire
